// >>> rtl/sre_device.sv
// Device end: decodes register and array read commands from the link.
// Assumes user logic answers mem_addr_o with mem_data_i in the same clock.
`default_nettype none
`include "sre_defines.svh"

// Contract
// [RL1] Config/safety read loops config then safety bytes
// [RL2] Sample input on rise, shift out MSB on fall
// [RL3] Safety clear resets volatile safety bits at deselect
// [RL4] Safety clear only when deselected after eighth bit
// [RL5] Volatile read repeats volatile byte until deselect
// [RL6] Volatile read accepted at any time
// [RL7] Volatile write changes only buffer-enable bit
// [RL8] Volatile write needs write-enable latch set
// [RL9] Volatile write needs exactly one byte boundary
// [RL10] Volatile write applies at deselect, no delay
// [RL11] One-byte status write updates status fields
// [RL12] Two-byte write also updates drive and lock
// [RL13] Status/config write needs write-enable latch set
// [RL14] More than two data bytes discards write
// [RL15] Status/config write refused while write busy
// [RL16] Status/config write needs deselect on boundary
// [RL17] Plain read: opcode, address, then data out
// [RL18] Array read increments address, wraps to zero
// [RL19] Fast read outputs after eight dummy clocks
// [RL20] Dummy clocks ignore input, outputs stay off
// [RL21] Dual read sends two bits per fall
// [RL22] Write-enable opcode sets write-enable latch
// [RL23] Deselect floats outputs and clears bit counter
module sre_device
   import sre_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Link
   sre_link_if.dev link,
   // Array read port
   output logic [23:0] mem_addr_o,
   input wire logic [7:0] mem_data_i,
   // Write engine and safety events
   input wire logic wip_i,
   input wire logic buf_loaded_i,
   input wire logic [7:0] safety_evt_i,
   // Register contents
   output logic [7:0] status_o,
   output logic [7:0] cfg_o,
   output logic [7:0] safety_o,
   output logic [7:0] volatile_o
);

   sre_dev_regs_t q;
   sre_dev_regs_t n;
   logic rise;
   logic fall;
   logic sel_rise;
   logic write_enable_latch;
   logic dual;
   logic [7:0] op_now;
   logic [7:0] ld_byte;

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      rise = q.sck_s & ~q.sck_p;
      fall = ~q.sck_s & q.sck_p;
      sel_rise = q.sel_s & ~q.sel_p;
      write_enable_latch = q.status[`SRE_WRITE_ENABLE_LATCH];
      dual = q.op == `SRE_FAST_DUAL_READ_CMD;
      op_now = {q.win[6:0], q.din_s};
      ld_byte = mem_data_i;
      n = q;
      // Link synchronisers
      n.sck_m = link.sck;
      n.sck_s = q.sck_m;
      n.sck_p = q.sck_s;
      n.sel_m = link.sel_n;
      n.sel_s = q.sel_m;
      n.sel_p = q.sel_s;
      n.din_m = link.io0;
      n.din_s = q.din_m;
      // Live flags from the rest of the device
      n.status[`SRE_WIP_BIT] = wip_i;
      n.vol[`SRE_BUFFER_LOADED_FLAG] = buf_loaded_i;
      if (q.sel_s) begin
         // Deselected: idle outputs, restart frame
         n.bits = 6'h0; // [RL23]
         n.ph = DP_OPC;
         n.ocnt = 3'h0;
         n.pair = 1'b0;
         n.io0_oe = 1'b0; // [RL23]
         n.io1_oe = 1'b0; // [RL23]
         if (sel_rise && q.bits[2:0] == 3'h0) begin
            case (q.op)
               `SRE_WRITE_ENABLE_CMD: begin
                  if (q.bits == `SRE_OPC_BITS) begin
                     n.status[`SRE_WRITE_ENABLE_LATCH] = 1'b1; // [RL22]
                  end
               end
               `SRE_SAFETY_CLEAR_CMD: begin
                  if (q.bits == `SRE_OPC_BITS) begin // [RL4]
                     n.safety = q.safety & ~`SRE_SAFETY_VOLATILE_MASK; // [RL3]
                  end
               end
               `SRE_VOLATILE_WRITE_CMD: begin
                  if (q.bits == `SRE_ONE_BYTE_FRAME && write_enable_latch) begin // [RL8] [RL9]
                     n.vol[`SRE_BUFFER_ENABLE_BIT] = q.wb0[`SRE_BUFFER_ENABLE_BIT]; // [RL7] [RL10]
                  end
               end
               `SRE_STATUS_CFG_WRITE_CMD: begin
                  // Longer frames fail both length checks
                  if ((q.bits == `SRE_ONE_BYTE_FRAME || q.bits == `SRE_TWO_BYTE_FRAME) // [RL14] [RL16]
                     && write_enable_latch && !wip_i) begin // [RL13] [RL15]
                     n.status = (q.status & ~`SRE_STATUS_WR_MASK)
                        | (q.wb0 & `SRE_STATUS_WR_MASK); // [RL11]
                     n.status[`SRE_WIP_BIT] = wip_i;
                     if (q.bits == `SRE_TWO_BYTE_FRAME) begin
                        n.cfg = (q.cfg & ~`SRE_CFG_WR_MASK) | (q.wb1 & `SRE_CFG_WR_MASK); // [RL12]
                        // Lock bit cannot be cleared once set
                        n.cfg[`SRE_ID_PAGE_LOCK_BIT] = q.cfg[`SRE_ID_PAGE_LOCK_BIT]
                           | q.wb1[`SRE_ID_PAGE_LOCK_BIT];
                     end
                  end
               end
               default: begin
               end
            endcase
         end
      end else if (rise) begin
         // Input bits taken on rising clock
         n.win = op_now; // [RL2]
         if (q.bits != 6'h3f) begin
            n.bits = q.bits + 6'h1;
         end
         case (q.ph)
            DP_OPC: begin
               if (q.bits == `SRE_OPC_LAST) begin
                  n.op = op_now;
                  case (op_now)
                     `SRE_READ_CMD,
                     `SRE_FAST_SINGLE_READ_CMD,
                     `SRE_FAST_DUAL_READ_CMD: n.ph = DP_ADDR;
                     `SRE_CFG_SAFETY_READ_CMD,
                     `SRE_VOLATILE_READ_CMD,
                     `SRE_VOLATILE_READ_ALT_CMD: n.ph = DP_OUT; // [RL6]
                     `SRE_VOLATILE_WRITE_CMD,
                     `SRE_STATUS_CFG_WRITE_CMD: n.ph = DP_WDATA;
                     default: n.ph = DP_IGNORE;
                  endcase
               end
            end
            DP_ADDR: begin
               n.addr = {q.addr[22:0], q.din_s};
               if (q.bits == `SRE_ADDR_LAST) begin
                  n.ph = (q.op == `SRE_READ_CMD) ? DP_OUT : DP_DUMMY; // [RL17] [RL19]
               end
            end
            DP_DUMMY: begin
               // Input ignored, outputs held off
               if (q.bits == `SRE_DUMMY_LAST) begin // [RL20]
                  n.ph = DP_OUT; // [RL19]
               end
            end
            DP_WDATA: begin
               if (q.bits == `SRE_BYTE1_LAST) begin
                  n.wb0 = op_now;
               end
               if (q.bits == `SRE_BYTE2_LAST) begin
                  n.wb1 = op_now;
               end
            end
            default: begin
            end
         endcase
      end else if (fall && q.ph == DP_OUT) begin
         // Output bits change on falling clock
         if (q.ocnt == 3'h0) begin
            case (q.op)
               `SRE_CFG_SAFETY_READ_CMD: begin
                  ld_byte = q.pair ? q.safety : q.cfg; // [RL1]
                  n.pair = ~q.pair; // [RL1]
               end
               `SRE_VOLATILE_READ_CMD,
               `SRE_VOLATILE_READ_ALT_CMD: begin
                  ld_byte = q.vol; // [RL5]
               end
               default: begin
                  ld_byte = mem_data_i; // [RL17]
                  n.addr = q.addr + 24'h1; // [RL18]
               end
            endcase
            n.io1 = ld_byte[7]; // [RL2]
            n.io1_oe = 1'b1;
            if (dual) begin
               n.io0 = ld_byte[6]; // [RL21]
               n.io0_oe = 1'b1;
               n.sh = {ld_byte[5:0], 2'b00};
               n.ocnt = 3'd3;
            end else begin
               n.sh = {ld_byte[6:0], 1'b0};
               n.ocnt = 3'd7;
            end
         end else begin
            n.io1 = q.sh[7];
            n.ocnt = q.ocnt - 3'h1;
            if (dual) begin
               n.io0 = q.sh[6]; // [RL21]
               n.sh = {q.sh[5:0], 2'b00};
            end else begin
               n.sh = {q.sh[6:0], 1'b0};
            end
         end
      end
      // New safety events win over a clear
      n.safety = n.safety | safety_evt_i;
   end

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         q <= '0;
         {q.sel_m, q.sel_s, q.sel_p} <= 3'b111;
         q.status <= `SRE_STATUS_RST;
         q.cfg <= `SRE_CFG_RST;
         q.safety <= `SRE_SAFETY_RST;
         q.vol <= `SRE_VOLATILE_RST;
      end else begin
         q <= n;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   assign mem_addr_o = q.addr;
   assign status_o = q.status;
   assign cfg_o = q.cfg;
   assign safety_o = q.safety;
   assign volatile_o = q.vol;
   assign link.io0_s = q.io0;
   assign link.io0_s_oe = q.io0_oe;
   assign link.io1_s = q.io1;
   assign link.io1_s_oe = q.io1_oe;

endmodule : sre_device

`default_nettype wire

// >>> rtl/sre_defines.svh
// Constants of the serial register/read command block.
// Assumes inclusion by bare name from both link ends, the checker and the bench.
`ifndef SRE_DEFINES_SVH
`define SRE_DEFINES_SVH

// Opcodes
`define SRE_WRITE_ENABLE_CMD 8'h06
`define SRE_CFG_SAFETY_READ_CMD 8'h15
`define SRE_SAFETY_CLEAR_CMD 8'h50
`define SRE_VOLATILE_READ_CMD 8'h85
`define SRE_VOLATILE_READ_ALT_CMD 8'h35
`define SRE_VOLATILE_WRITE_CMD 8'h81
`define SRE_STATUS_CFG_WRITE_CMD 8'h01
`define SRE_READ_CMD 8'h03
`define SRE_FAST_SINGLE_READ_CMD 8'h0b
`define SRE_FAST_DUAL_READ_CMD 8'h3b

// Frame bit positions, counted in rising clock edges
`define SRE_OPC_LAST 6'd7
`define SRE_OPC_BITS 6'd8
`define SRE_BYTE1_LAST 6'd15
`define SRE_ONE_BYTE_FRAME 6'd16
`define SRE_BYTE2_LAST 6'd23
`define SRE_TWO_BYTE_FRAME 6'd24
`define SRE_ADDR_LAST 6'd31
`define SRE_DUMMY_LAST 6'd39
`define SRE_RD_HDR_BITS 6'd32
`define SRE_FAST_HDR_BITS 6'd40

// Status register fields
`define SRE_WIP_BIT 0
`define SRE_WRITE_ENABLE_LATCH 1
`define SRE_STATUS_WR_MASK 8'hde
`define SRE_STATUS_RST 8'h00

// Configuration register fields
`define SRE_ID_PAGE_LOCK_BIT 7
`define SRE_CFG_WR_MASK 8'h83
`define SRE_CFG_RST 8'h00

// Safety and volatile register fields
`define SRE_SAFETY_VOLATILE_MASK 8'hff
`define SRE_SAFETY_RST 8'h00
`define SRE_BUFFER_ENABLE_BIT 1
`define SRE_BUFFER_LOADED_FLAG 0
`define SRE_VOLATILE_RST 8'h00

`endif

// >>> rtl/sre_pkg.sv
// Types shared by the two ends of the serial register/read link.
// Assumes sre_defines.svh holds the numeric constants.
`default_nettype none

package sre_pkg;

   typedef enum logic [2:0] {
      DP_OPC = 3'b000,
      DP_ADDR = 3'b001,
      DP_DUMMY = 3'b010,
      DP_OUT = 3'b011,
      DP_WDATA = 3'b100,
      DP_IGNORE = 3'b101
   } sre_dev_phase_t;

   typedef enum logic [1:0] {
      HS_IDLE = 2'b00,
      HS_SHIFT = 2'b01,
      HS_TAIL = 2'b10
   } sre_host_state_t;

   typedef struct packed {
      logic sck_m;
      logic sck_s;
      logic sck_p;
      logic sel_m;
      logic sel_s;
      logic sel_p;
      logic din_m;
      logic din_s;
      logic [5:0] bits;
      sre_dev_phase_t ph;
      logic [7:0] win;
      logic [7:0] op;
      logic [23:0] addr;
      logic [7:0] wb0;
      logic [7:0] wb1;
      logic [7:0] sh;
      logic [2:0] ocnt;
      logic pair;
      logic [7:0] status;
      logic [7:0] cfg;
      logic [7:0] safety;
      logic [7:0] vol;
      logic io0;
      logic io0_oe;
      logic io1;
      logic io1_oe;
   } sre_dev_regs_t;

   typedef struct packed {
      sre_host_state_t st;
      logic [7:0] hc;
      logic sck;
      logic sel_n;
      logic mosi;
      logic mosi_oe;
      logic [39:0] tx;
      logic [5:0] txn;
      logic dual;
      logic [15:0] rxn;
      logic [7:0] rsh;
      logic [3:0] rbits;
      logic [1:0][7:0] fb;
      logic [1:0] fcnt;
      logic fhead;
      logic rx_valid;
      logic [7:0] rx_data;
      logic cmd_ready;
      logic io0_m;
      logic io0_s;
      logic io1_m;
      logic io1_s;
   } sre_host_regs_t;

endpackage : sre_pkg

`default_nettype wire

// >>> rtl/sre_link_if.sv
// Serial link between bus master and memory device.
// Assumes idle lines are pulled high when neither end drives them.
`default_nettype none

interface sre_link_if;
   logic sel_n;
   logic sck;
   logic io0_m;
   logic io0_m_oe;
   logic io0_s;
   logic io0_s_oe;
   logic io1_s;
   logic io1_s_oe;
   logic io0;
   logic io1;

   // Resolved line levels
   assign io0 = io0_s_oe ? io0_s : (io0_m_oe ? io0_m : 1'b1);
   assign io1 = io1_s_oe ? io1_s : 1'b1;

   modport dev(input sel_n, input sck, input io0,
      output io0_s, output io0_s_oe, output io1_s, output io1_s_oe);
   modport host(output sel_n, output sck, output io0_m, output io0_m_oe,
      input io0, input io1);
endinterface : sre_link_if

`default_nettype wire

// >>> rtl/sre_host.sv
// Bus master end: sends one command frame and streams read bytes out.
// Assumes a partner device on sre_link_if; makes the serial clock itself.
`default_nettype none
`include "sre_defines.svh"

module sre_host
   import sre_pkg::*;
#(
   parameter logic [7:0] HALF = 8'd8
)
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Command
   input wire logic cmd_valid_i,
   output logic cmd_ready_o,
   input wire logic [7:0] cmd_op_i,
   input wire logic [23:0] cmd_addr_i,
   input wire logic [1:0] cmd_nwr_i,
   input wire logic [23:0] cmd_wdata_i,
   input wire logic [15:0] cmd_nrd_i,
   // Read stream
   output logic rx_valid_o,
   input wire logic rx_ready_i,
   output logic [7:0] rx_data_o,
   // Link
   sre_link_if.host link
);

   sre_host_regs_t q;
   sre_host_regs_t n;
   logic pop;
   logic push;
   logic is_addr;
   logic fast;
   logic [7:0] rsh_nx;
   logic [3:0] rbits_nx;

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      pop = q.rx_valid & rx_ready_i;
      push = 1'b0;
      fast = (cmd_op_i == `SRE_FAST_SINGLE_READ_CMD) || (cmd_op_i == `SRE_FAST_DUAL_READ_CMD);
      is_addr = fast || (cmd_op_i == `SRE_READ_CMD);
      rsh_nx = q.dual ? {q.rsh[5:0], q.io1_s, q.io0_s} : {q.rsh[6:0], q.io1_s};
      rbits_nx = q.rbits + (q.dual ? 4'd2 : 4'd1);
      n = q;
      n.io0_m = link.io0;
      n.io0_s = q.io0_m;
      n.io1_m = link.io1;
      n.io1_s = q.io1_m;
      case (q.st)
         HS_IDLE: begin
            n.sck = 1'b0;
            if (cmd_valid_i && q.cmd_ready) begin
               // Opcode, then address and dummy or write bytes
               n.tx = is_addr ? {cmd_op_i, cmd_addr_i, 8'h00} : {cmd_op_i, cmd_wdata_i, 8'h00}; // [RL17]
               n.txn = is_addr ? (fast ? `SRE_FAST_HDR_BITS : `SRE_RD_HDR_BITS) // [RL19]
                  : `SRE_OPC_BITS + {1'b0, cmd_nwr_i, 3'b000};
               n.dual = cmd_op_i == `SRE_FAST_DUAL_READ_CMD;
               n.rxn = cmd_nrd_i;
               n.rbits = 4'h0;
               n.sel_n = 1'b0;
               n.mosi = cmd_op_i[7];
               n.mosi_oe = 1'b1;
               n.hc = 8'h00;
               n.st = HS_SHIFT;
            end
         end
         HS_SHIFT: begin
            if (q.hc != HALF - 8'd1) begin
               n.hc = q.hc + 8'd1;
            end else if (!q.sck) begin
               if (q.txn == 6'h0 && q.rxn == 16'h0) begin
                  n.sel_n = 1'b1; // [RL4] [RL9] [RL16]
                  n.hc = 8'h00;
                  n.st = HS_TAIL;
               end else if (!(q.txn == 6'h0 && q.fcnt == 2'd2)) begin
                  n.sck = 1'b1; // [RL2]
                  n.hc = 8'h00;
               end
            end else begin
               n.sck = 1'b0;
               n.hc = 8'h00;
               if (q.txn != 6'h0) begin
                  n.txn = q.txn - 6'h1;
                  n.tx = {q.tx[38:0], 1'b0};
                  n.mosi = q.tx[38];
                  if (q.txn == 6'h1 && q.dual) begin
                     n.mosi_oe = 1'b0; // [RL21]
                  end
               end else begin
                  n.rsh = rsh_nx;
                  if (rbits_nx == 4'd8) begin
                     push = 1'b1;
                     n.rbits = 4'h0;
                     n.rxn = q.rxn - 16'h1;
                  end else begin
                     n.rbits = rbits_nx;
                  end
               end
            end
         end
         HS_TAIL: begin
            n.mosi_oe = 1'b0;
            if (q.hc != HALF - 8'd1) begin
               n.hc = q.hc + 8'd1;
            end else begin
               n.st = HS_IDLE;
            end
         end
         default: begin
            n.st = HS_IDLE;
         end
      endcase
      // Two-entry receive buffer
      if (push) begin
         n.fb[q.fhead ^ q.fcnt[0]] = rsh_nx;
      end
      if (pop) begin
         n.fhead = ~q.fhead;
      end
      case ({push, pop})
         2'b10: n.fcnt = q.fcnt + 2'd1;
         2'b01: n.fcnt = q.fcnt - 2'd1;
         default: n.fcnt = q.fcnt;
      endcase
      n.rx_valid = n.fcnt != 2'd0;
      n.rx_data = n.fb[n.fhead];
      n.cmd_ready = n.st == HS_IDLE;
   end

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         q <= '0;
         q.sel_n <= 1'b1;
      end else begin
         q <= n;
      end
   end

   assign cmd_ready_o = q.cmd_ready;
   assign rx_valid_o = q.rx_valid;
   assign rx_data_o = q.rx_data;
   assign link.sel_n = q.sel_n;
   assign link.sck = q.sck;
   assign link.io0_m = q.mosi;
   assign link.io0_m_oe = q.mosi_oe;

endmodule : sre_host

`default_nettype wire

// >>> testbench/sre_monitor.sv
// Checker of the serial link between the bus master and device ends.
// Assumes plain copies of the interface lines plus block clock and reset.
`default_nettype none
`include "sre_defines.svh"

module sre_monitor (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Link lines
   input wire logic sel_n,
   input wire logic sck,
   input wire logic io0_m,
   input wire logic io0_m_oe,
   input wire logic io0_s,
   input wire logic io0_s_oe,
   input wire logic io1_s,
   input wire logic io1_s_oe
);
   timeunit 1ns;
   timeprecision 1ps;

   ////////////////////////////////////////////////////////////////////////////////
   // Frame tracking: clock rises and opcode
   logic sck_q;
   logic rise;
   logic fast;
   logic [5:0] cnt;
   logic [7:0] op;

   assign rise = sck && !sck_q;
   assign fast = op == `SRE_FAST_SINGLE_READ_CMD || op == `SRE_FAST_DUAL_READ_CMD;

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         sck_q <= 1'b0;
         cnt <= 6'h00;
         op <= 8'h00;
      end else begin
         sck_q <= sck;
         if (sel_n) begin
            cnt <= 6'h00;
         end else if (rise && cnt != 6'h3f) begin
            cnt <= cnt + 6'h01;
         end
         if (!sel_n && rise && cnt < 6'h08) begin
            op <= {op[6:0], io0_m};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Assertions
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   desel_float_a: assert property (sel_n [*5] |-> !io1_s_oe && !io0_s_oe)
      else $error("outputs driven while deselected");
   idle_sck_a: assert property (sel_n |-> !sck)
      else $error("serial clock not idle low");
   opc_stable_a: assert property (!sel_n && cnt < 6'h08 && rise |-> io0_m_oe && $stable(io0_m))
      else $error("opcode bit moved at clock rise");
   out_on_fall_a: assert property ((io1_s_oe && $changed(io1_s)) || (io0_s_oe && $changed(io0_s))
      |-> !sck)
      else $error("output changed while clock high");
   hdr_quiet_a: assert property (!sel_n && cnt < 6'h08 |-> !io1_s_oe && !io0_s_oe)
      else $error("output driven during opcode");
   dummy_hiz_a: assert property (!sel_n && fast && cnt < 6'h28 |-> !io1_s_oe && !io0_s_oe)
      else $error("output driven before dummy clocks end");
   read_start_a: assert property (!sel_n && op == `SRE_READ_CMD && cnt == 6'h21 |-> io1_s_oe)
      else $error("plain read data missing");
   fast_single_a: assert property (!sel_n && op == `SRE_FAST_SINGLE_READ_CMD && cnt == 6'h29
      |-> io1_s_oe && !io0_s_oe)
      else $error("fast single read lines wrong");
   dual_two_a: assert property (!sel_n && op == `SRE_FAST_DUAL_READ_CMD && cnt == 6'h29
      |-> io1_s_oe && io0_s_oe)
      else $error("dual read lines wrong");

   plain_read_c: cover property (!sel_n && op == `SRE_READ_CMD && io1_s_oe);
   dual_read_c: cover property (!sel_n && op == `SRE_FAST_DUAL_READ_CMD && io0_s_oe);
   cfg_read_c: cover property (!sel_n && op == `SRE_CFG_SAFETY_READ_CMD && io1_s_oe);
endmodule : sre_monitor

`default_nettype wire

// >>> testbench/test_serial_eeprom_reg_and_read_cmds.sv
// Bench joining the bus master and device ends through the link interface.
// Assumes design files and the checker are compiled before it.
`default_nettype none
`include "sre_defines.svh"

module test_serial_eeprom_reg_and_read_cmds;
   timeunit 1ns;
   timeprecision 1ps;

   localparam int LIMIT = 80000;
   logic clk_i, rst_i, cmd_valid_i, cmd_ready_o, rx_valid_o, rx_ready_i;
   logic [7:0] cmd_op_i, rx_data_o, mem_data_i, safety_evt_i;
   logic [23:0] cmd_addr_i, cmd_wdata_i, mem_addr_o;
   logic [1:0] cmd_nwr_i;
   logic [15:0] cmd_nrd_i;
   logic wip_i, buf_loaded_i;
   logic [7:0] status_o, cfg_o, safety_o, volatile_o;
   logic [7:0] rxq[$];
   int miscompares = 0;
   int num_checks = 0;
   int cycles = 0;

   ////////////////////////////////////////////////////////////////////////////////
   // Ends, link and checker
   function automatic logic [7:0] mem_byte(input logic [23:0] a);
      return a[7:0] ^ a[23:16] ^ 8'h3c;
   endfunction : mem_byte

   assign mem_data_i = mem_byte(mem_addr_o);
   sre_link_if sre_link_if_i ();
   sre_host #(.HALF(8'd6)) sre_host_i (.clk_i(clk_i), .rst_i(rst_i), .cmd_valid_i(cmd_valid_i),
      .cmd_ready_o(cmd_ready_o), .cmd_op_i(cmd_op_i), .cmd_addr_i(cmd_addr_i),
      .cmd_nwr_i(cmd_nwr_i), .cmd_wdata_i(cmd_wdata_i), .cmd_nrd_i(cmd_nrd_i),
      .rx_valid_o(rx_valid_o), .rx_ready_i(rx_ready_i), .rx_data_o(rx_data_o),
      .link(sre_link_if_i));
   sre_device sre_device_i (.clk_i(clk_i), .rst_i(rst_i), .link(sre_link_if_i),
      .mem_addr_o(mem_addr_o), .mem_data_i(mem_data_i), .wip_i(wip_i),
      .buf_loaded_i(buf_loaded_i), .safety_evt_i(safety_evt_i), .status_o(status_o),
      .cfg_o(cfg_o), .safety_o(safety_o), .volatile_o(volatile_o));
   sre_monitor sre_monitor_i (.clk_i(clk_i), .rst_i(rst_i), .sel_n(sre_link_if_i.sel_n),
      .sck(sre_link_if_i.sck), .io0_m(sre_link_if_i.io0_m), .io0_m_oe(sre_link_if_i.io0_m_oe),
      .io0_s(sre_link_if_i.io0_s), .io0_s_oe(sre_link_if_i.io0_s_oe),
      .io1_s(sre_link_if_i.io1_s), .io1_s_oe(sre_link_if_i.io1_s_oe));

   ////////////////////////////////////////////////////////////////////////////////
   // Clock, byte collector, timeout
   always #5 clk_i = ~clk_i;

   always @(posedge clk_i) begin
      cycles++;
      if (rx_valid_o === 1'b1 && rx_ready_i === 1'b1) begin
         rxq.push_back(rx_data_o);
      end
      if (cycles == LIMIT) begin
         miscompares++;
         $display("MISMATCH %0t timeout", $time);
         print_verdict();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Shared tasks
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : print_verdict

   task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : check

   task automatic wait_ready();
      for (int n = 0; n < 9000 && cmd_ready_o !== 1'b1; n++) begin
         @(negedge clk_i);
      end
   endtask : wait_ready

   task automatic send(input logic [7:0] op, input logic [23:0] addr, input logic [1:0] nwr,
      input logic [23:0] wd, input int nrd, input int stall);
      rxq = {};
      wait_ready();
      cmd_op_i = op;
      cmd_addr_i = addr;
      cmd_nwr_i = nwr;
      cmd_wdata_i = wd;
      cmd_nrd_i = 16'(nrd);
      cmd_valid_i = 1'b1;
      @(negedge clk_i);
      cmd_valid_i = 1'b0;
      rx_ready_i = (stall == 0);
      repeat (stall + 2) @(negedge clk_i);
      rx_ready_i = 1'b1;
      wait_ready();
      repeat (6) @(negedge clk_i);
   endtask : send

   task automatic regs(input logic [7:0] st, input logic [7:0] cf, input logic [7:0] vo);
      check(status_o, st, "status");
      check(cfg_o, cf, "config");
      check(volatile_o, vo, "volatile");
   endtask : regs

   task automatic rx_same(input int n, input logic [7:0] a, input logic [7:0] b);
      check(8'(rxq.size()), 8'(n), "byte count");
      for (int i = 0; i < n; i++) begin
         check(rxq[i], i[0] ? b : a, "register byte");
      end
   endtask : rx_same

   task automatic read_case(input logic [7:0] op, input logic [23:0] addr, input int n,
      input int stall);
      send(op, addr, 2'd0, 24'h0, n, stall);
      check(8'(rxq.size()), 8'(n), "read count");
      for (int i = 0; i < n; i++) begin
         check(rxq[i], mem_byte(addr + 24'(i)), "read data");
      end
   endtask : read_case

   ////////////////////////////////////////////////////////////////////////////////
   // Scenarios
   task automatic t_latch();
      send(`SRE_VOLATILE_WRITE_CMD, 24'h0, 2'd1, 24'hff0000, 0, 0);
      regs(8'h00, 8'h00, 8'h00);
      send(`SRE_WRITE_ENABLE_CMD, 24'h0, 2'd0, 24'h0, 0, 0);
      regs(8'h02, 8'h00, 8'h00);
      send(`SRE_VOLATILE_WRITE_CMD, 24'h0, 2'd2, 24'hffff00, 0, 0);
      regs(8'h02, 8'h00, 8'h00);
      send(`SRE_VOLATILE_WRITE_CMD, 24'h0, 2'd1, 24'hff0000, 0, 0);
      regs(8'h02, 8'h00, 8'h02);
      $display("test latch done");
   endtask : t_latch

   task automatic t_volread();
      wip_i = 1'b1;
      buf_loaded_i = 1'b1;
      repeat (4) @(negedge clk_i);
      send(`SRE_VOLATILE_READ_CMD, 24'h0, 2'd0, 24'h0, 3, 0);
      rx_same(3, 8'h03, 8'h03);
      send(`SRE_VOLATILE_READ_ALT_CMD, 24'h0, 2'd0, 24'h0, 2, 0);
      rx_same(2, 8'h03, 8'h03);
      send(`SRE_STATUS_CFG_WRITE_CMD, 24'h0, 2'd2, 24'hffff00, 0, 0);
      regs(8'h03, 8'h00, 8'h03);
      wip_i = 1'b0;
      buf_loaded_i = 1'b0;
      $display("test volatile read done");
   endtask : t_volread

   task automatic t_status();
      send(`SRE_STATUS_CFG_WRITE_CMD, 24'h0, 2'd3, 24'hffffff, 0, 0);
      regs(8'h02, 8'h00, 8'h02);
      send(`SRE_STATUS_CFG_WRITE_CMD, 24'h0, 2'd2, 24'hffff00, 0, 0);
      regs(8'hde, 8'h83, 8'h02);
      send(`SRE_STATUS_CFG_WRITE_CMD, 24'h0, 2'd1, 24'h000000, 0, 0);
      regs(8'h00, 8'h83, 8'h02);
      send(`SRE_STATUS_CFG_WRITE_CMD, 24'h0, 2'd2, 24'hffff00, 0, 0);
      regs(8'h00, 8'h83, 8'h02);
      $display("test status done");
   endtask : t_status

   task automatic t_safety();
      safety_evt_i = 8'h24;
      @(negedge clk_i);
      safety_evt_i = 8'h00;
      repeat (3) @(negedge clk_i);
      check(safety_o, 8'h24, "sticky flags");
      send(`SRE_CFG_SAFETY_READ_CMD, 24'h0, 2'd0, 24'h0, 4, 0);
      rx_same(4, 8'h83, 8'h24);
      send(`SRE_SAFETY_CLEAR_CMD, 24'h0, 2'd1, 24'h550000, 0, 0);
      check(safety_o, 8'h24, "late clear");
      send(`SRE_SAFETY_CLEAR_CMD, 24'h0, 2'd0, 24'h0, 0, 0);
      check(safety_o, 8'h00, "clear");
      $display("test safety done");
   endtask : t_safety

   task automatic t_reads();
      read_case(`SRE_READ_CMD, 24'hfffffe, 4, 0);
      read_case(`SRE_FAST_SINGLE_READ_CMD, 24'h000010, 2, 0);
      read_case(`SRE_FAST_DUAL_READ_CMD, 24'h0000fd, 6, 3000);
      $display("test reads done");
   endtask : t_reads

   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      clk_i = 1'b0;
      rst_i = 1'b1;
      cmd_valid_i = 1'b0;
      cmd_op_i = 8'h00;
      cmd_addr_i = 24'h0;
      cmd_nwr_i = 2'd0;
      cmd_wdata_i = 24'h0;
      cmd_nrd_i = 16'h0;
      rx_ready_i = 1'b1;
      wip_i = 1'b0;
      buf_loaded_i = 1'b0;
      safety_evt_i = 8'h00;
      repeat (12) @(posedge clk_i);
      @(negedge clk_i);
      rst_i = 1'b0;
      repeat (4) @(negedge clk_i);
      regs(8'h00, 8'h00, 8'h00);
      check(safety_o, 8'h00, "safety reset");
      t_latch();
      t_volread();
      t_status();
      t_safety();
      t_reads();
      print_verdict();
   end
endmodule : test_serial_eeprom_reg_and_read_cmds

`default_nettype wire
